/* pkg/ppc_defs.svh */
// Behaviour
// - Bit 7 disables both debug pin pullups.
// - Bit 6 disables test-access pin pulls.
// - Bit 5 disables interrupt/watchdog pin pullup.
// - Bit 4 disables host control pin pulls.
// - Bit 3 disables host data bus holders.
// - Bit 2 disables memory control pin features.
// - Bit 1 disables memory data bus holders.
// - Bit 0 disables memory address bus holders.
// - At 0x8800, upper byte zero, reset 0.
// - Pull follows bit regardless of pin function.
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH
`define PPC_ADDR_REG       16'h8800
`define PPC_RESET_VALUE    8'h00
`define PPC_RESET_BIT      1'b0
`define PPC_BIT_DEBUG      7
`define PPC_BIT_TEST       6
`define PPC_BIT_INTR       5
`define PPC_BIT_HOST_CTRL  4
`define PPC_BIT_HOST_DATA  3
`define PPC_BIT_MEM_CTRL   2
`define PPC_BIT_MEM_DATA   1
`define PPC_BIT_MEM_ADDR   0
`define PPC_RESERVED_READ  8'h00
`define PPC_READ_NONE      16'h0000
`endif

/* pkg/ppc_pkg.sv */
`default_nettype none
package ppc_pkg;
  typedef struct packed {
    logic debug_pin_pull_disable;
    logic test_pin_pull_disable;
    logic intr_pin_pull_disable;
    logic host_ctrl_pull_disable;
    logic host_data_hold_disable;
    logic mem_ctrl_pull_disable;
    logic mem_data_hold_disable;
    logic mem_addr_hold_disable;
  } ppc_ctrl_t;

  typedef struct packed {
    logic debug_pull_en;
    logic test_pull_en;
    logic intr_pull_en;
    logic host_ctrl_pull_en;
    logic host_data_hold_en;
    logic mem_ctrl_pull_en;
    logic mem_data_hold_en;
    logic mem_addr_hold_en;
  } ppc_pad_en_t;
endpackage : ppc_pkg
`default_nettype wire

/* logic/ppc_pad_pull_control.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defs.svh"
module ppc_pad_pull_control (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [15:0]          addr_i,
  input  wire logic [15:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output var  logic [15:0]          rdata_o,
  output var  ppc_pkg::ppc_pad_en_t pad_en_o
);

  // ************************************************************
  // Address decode.
  // ************************************************************
  logic hit;
  logic wr_hit;
  logic rd_hit;

  always_comb begin
    if (addr_i == `PPC_ADDR_REG) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_hit = wr_i && hit;
  assign rd_hit = rd_i && hit;

  // ************************************************************
  // Control bits and their next values.
  // ************************************************************
  logic debug_pin_pull_disable;
  logic test_pin_pull_disable;
  logic intr_pin_pull_disable;
  logic host_ctrl_pull_disable;
  logic host_data_hold_disable;
  logic mem_ctrl_pull_disable;
  logic mem_data_hold_disable;
  logic mem_addr_hold_disable;

  logic next_debug_pin_pull_disable;
  logic next_test_pin_pull_disable;
  logic next_intr_pin_pull_disable;
  logic next_host_ctrl_pull_disable;
  logic next_host_data_hold_disable;
  logic next_mem_ctrl_pull_disable;
  logic next_mem_data_hold_disable;
  logic next_mem_addr_hold_disable;

  // ************************************************************
  // Write path, one bit for each pin group.
  // ************************************************************
  always_comb begin
    if (wr_hit) begin
      next_debug_pin_pull_disable = wdata_i[`PPC_BIT_DEBUG];
    end else begin
      next_debug_pin_pull_disable = debug_pin_pull_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_test_pin_pull_disable = wdata_i[`PPC_BIT_TEST];
    end else begin
      next_test_pin_pull_disable = test_pin_pull_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_intr_pin_pull_disable = wdata_i[`PPC_BIT_INTR];
    end else begin
      next_intr_pin_pull_disable = intr_pin_pull_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_host_ctrl_pull_disable = wdata_i[`PPC_BIT_HOST_CTRL];
    end else begin
      next_host_ctrl_pull_disable = host_ctrl_pull_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_host_data_hold_disable = wdata_i[`PPC_BIT_HOST_DATA];
    end else begin
      next_host_data_hold_disable = host_data_hold_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_mem_ctrl_pull_disable = wdata_i[`PPC_BIT_MEM_CTRL];
    end else begin
      next_mem_ctrl_pull_disable = mem_ctrl_pull_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_mem_data_hold_disable = wdata_i[`PPC_BIT_MEM_DATA];
    end else begin
      next_mem_data_hold_disable = mem_data_hold_disable;
    end
  end

  always_comb begin
    if (wr_hit) begin
      next_mem_addr_hold_disable = wdata_i[`PPC_BIT_MEM_ADDR];
    end else begin
      next_mem_addr_hold_disable = mem_addr_hold_disable;
    end
  end

  // ************************************************************
  // Control bit registers, all cleared by reset.
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      debug_pin_pull_disable <= `PPC_RESET_BIT;
    end else begin
      debug_pin_pull_disable <= next_debug_pin_pull_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      test_pin_pull_disable <= `PPC_RESET_BIT;
    end else begin
      test_pin_pull_disable <= next_test_pin_pull_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      intr_pin_pull_disable <= `PPC_RESET_BIT;
    end else begin
      intr_pin_pull_disable <= next_intr_pin_pull_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      host_ctrl_pull_disable <= `PPC_RESET_BIT;
    end else begin
      host_ctrl_pull_disable <= next_host_ctrl_pull_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      host_data_hold_disable <= `PPC_RESET_BIT;
    end else begin
      host_data_hold_disable <= next_host_data_hold_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mem_ctrl_pull_disable <= `PPC_RESET_BIT;
    end else begin
      mem_ctrl_pull_disable <= next_mem_ctrl_pull_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mem_data_hold_disable <= `PPC_RESET_BIT;
    end else begin
      mem_data_hold_disable <= next_mem_data_hold_disable;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mem_addr_hold_disable <= `PPC_RESET_BIT;
    end else begin
      mem_addr_hold_disable <= next_mem_addr_hold_disable;
    end
  end

  // ************************************************************
  // Register image as software sees it.
  // ************************************************************
  ppc_pkg::ppc_ctrl_t pad_pull_control;

  always_comb begin
    pad_pull_control.debug_pin_pull_disable = debug_pin_pull_disable;
    pad_pull_control.test_pin_pull_disable  = test_pin_pull_disable;
    pad_pull_control.intr_pin_pull_disable  = intr_pin_pull_disable;
    pad_pull_control.host_ctrl_pull_disable = host_ctrl_pull_disable;
    pad_pull_control.host_data_hold_disable = host_data_hold_disable;
    pad_pull_control.mem_ctrl_pull_disable  = mem_ctrl_pull_disable;
    pad_pull_control.mem_data_hold_disable  = mem_data_hold_disable;
    pad_pull_control.mem_addr_hold_disable  = mem_addr_hold_disable;
  end

  // ************************************************************
  // Read data, valid in the cycle after the read strobe.
  // ************************************************************
  logic [15:0] next_rdata;

  always_comb begin
    if (rd_hit) begin
      next_rdata = {`PPC_RESERVED_READ, pad_pull_control};
    end else begin
      next_rdata = `PPC_READ_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= `PPC_READ_NONE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ************************************************************
  // Pad enables, active high, independent of pin function.
  // ************************************************************
  always_comb begin
    pad_en_o.debug_pull_en     = ~debug_pin_pull_disable;
    pad_en_o.test_pull_en      = ~test_pin_pull_disable;
    pad_en_o.intr_pull_en      = ~intr_pin_pull_disable;
    pad_en_o.host_ctrl_pull_en = ~host_ctrl_pull_disable;
    pad_en_o.host_data_hold_en = ~host_data_hold_disable;
    pad_en_o.mem_ctrl_pull_en  = ~mem_ctrl_pull_disable;
    pad_en_o.mem_data_hold_en  = ~mem_data_hold_disable;
    pad_en_o.mem_addr_hold_en  = ~mem_addr_hold_disable;
  end

endmodule : ppc_pad_pull_control
`default_nettype wire

/* dv/ppc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ppc_chk(input wire logic core_clk_i,reset_i,wr_i,rd_i,input wire logic[15:0]addr_i,wdata_i,
rdata_o,input wire ppc_pkg::ppc_pad_en_t pad_en_o);wire logic m=addr_i==16'h8800,w=wr_i&&m;
default clocking@(posedge core_clk_i);endclocking default disable iff(reset_i);
property p_a;w|=>pad_en_o==~$past(wdata_i[7:0]);endproperty
a_a:assert property(p_a)else $error("bad");
property p_b;!w|=>$stable(pad_en_o);endproperty
a_b:assert property(p_b)else $error("bad");
property p_c;rd_i&&m|=>rdata_o=={8'h00,~pad_en_o};endproperty
a_c:assert property(p_c)else $error("bad");
property p_d;rd_i&&!m|=>!rdata_o;endproperty
a_d:assert property(p_d)else $error("bad");
property p_e;!rd_i|=>!rdata_o;endproperty
a_e:assert property(p_e)else $error("bad");
property p_f;disable iff(1'b0)reset_i|=>&pad_en_o;endproperty
a_f:assert property(p_f)else $error("bad");
property p_g;wr_i&&!m|=>$stable(pad_en_o);endproperty
a_g:assert property(p_g)else $error("bad");
property p_h;rd_i|->##1!rdata_o[15:8];endproperty
a_h:assert property(p_h)else $error("bad");
cover property(w);cover property(rd_i&&m);cover property(wr_i&&!m);
endmodule:ppc_chk
bind ppc_pad_pull_control ppc_chk ppc_chk_i(.*);
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 core_clk   = 1'b0;
  logic                 reset      = 1'b1;
  logic                 wr         = 1'b0;
  logic                 rd         = 1'b0;
  logic [15:0]          addr       = 16'h0000;
  logic [15:0]          wdata      = 16'h0000;
  logic [15:0]          rdata;
  logic [15:0]          got;
  ppc_pkg::ppc_pad_en_t pad_en;
  int                   errors     = 0;
  int                   n_compared = 0;
  int                   cycles     = 0;

  always #5 core_clk = ~core_clk;

  ppc_pad_pull_control ppc_pad_pull_control_i (
    .core_clk_i (core_clk),
    .reset_i    (reset),
    .addr_i     (addr),
    .wdata_i    (wdata),
    .wr_i       (wr),
    .rd_i       (rd),
    .rdata_o    (rdata),
    .pad_en_o   (pad_en)
  );

  task automatic write_reg(input logic [15:0] a, input logic [15:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [15:0] a, output logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : read_reg

  task automatic check_word(input logic [15:0] actual, input logic [15:0] expected);
    n_compared++;
    if (actual !== expected) begin
      errors++;
      $display("wrong value at %0t: read data %h, expected %h", $time, actual, expected);
    end
  endtask : check_word

  task automatic check_enables(input logic [7:0] expected);
    #1;
    n_compared++;
    if (pad_en !== expected) begin
      errors++;
      $display("wrong value at %0t: pad enables %h, expected %h", $time, pad_en, expected);
    end
  endtask : check_enables

  task wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles >= 400) begin
      errors++;
      wrap_up;
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    check_enables(8'hff);
    read_reg(16'h8800, got);
    check_word(got, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      write_reg(16'h8800, 16'hff00 | (16'h0001 << i));
      check_enables(8'hff ^ (8'h01 << i));
      read_reg(16'h8800, got);
      check_word(got, 16'h0001 << i);
    end
    write_reg(16'h8800, 16'h00ff);
    check_enables(8'h00);
    read_reg(16'h8800, got);
    check_word(got, 16'h00ff);
    write_reg(16'h8801, 16'h0000);
    check_enables(8'h00);
    read_reg(16'h8801, got);
    check_word(got, 16'h0000);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    check_enables(8'hff);
    read_reg(16'h8800, got);
    check_word(got, 16'h0000);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
